// [design/aobcs_ctrl.sv]
// output buffer control/status register and its clock and flag logic
`timescale 1ns/1ps
module aobcs_ctrl
    import aobcs_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_rst_n,
    // register port
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic              i_wr,
    input  wire logic [31:0]       i_wdata,
    output logic      [31:0]       o_rdata,
    // buffer status from the fifo datapath, plus rate tick and bcr software clock/trigger
    input  wire logic              i_buf_empty,
    input  wire logic              i_buf_full,
    input  wire logic              i_buf_thresh,
    input  wire logic              i_frame_idx_zero,
    input  wire logic              i_host_buf_wr,
    input  wire logic              i_burst_ready,
    input  wire logic              i_ratec_tick,
    input  wire logic              i_bcr_sw_clk,
    input  wire logic              i_bcr_sw_trig,
    // controls to the datapath
    output logic      [1:0]        o_ch_active,
    output logic                   o_buf_clock,
    output logic                   o_buf_clear,
    output logic                   o_host_wr_accept,
    output logic                   o_circular,
    output logic                   o_load_ready,
    output logic                   o_burst_en,
    output logic                   o_trigger,
    output logic                   o_dma_swap,
    // bidirectional output clock pin
    input  wire logic              i_oclk_pin,
    output logic                   o_oclk_pin,
    output logic                   o_oclk_oe
);
    // refuse sizes that the decoder and the pulse counter cannot serve
    if (ADDR_W < 8) begin : g_addr_chk
        $error("ADDR_W too small for the register offset");
    end
    if (PULSE_CYC < 1 || PULSE_CYC > 7) begin : g_pulse_chk
        $error("pulse length does not fit its counter");
    end

    logic [31:0] ctl_q;
    logic        ld_rdy_q;
    logic        pin_q;
    logic [2:0]  pulse_cnt_q;
    logic        sel_wr;
    logic        clk_evt;
    logic        ext_fall;

    assign sel_wr = i_wr && (i_addr == ADDR_W'(AOBCS_OFF_CTRL));
    // falling edge of pin in target mode; generator ignored then
    assign ext_fall = pin_q && !i_oclk_pin;
    assign clk_evt = (ctl_q[B_CLK_SRC] ? i_ratec_tick : ext_fall);
    // software clock bypasses source selection and enable
    assign o_buf_clock = (clk_evt && ctl_q[B_CLK_EN])
                       || ctl_q[B_SW_CLK] || i_bcr_sw_clk;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_q <= 1'b1;
        end else begin
            pin_q <= i_oclk_pin;
        end
    end

    // control bits; pulses self-clear after one cycle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_q <= AOBCS_RST_VAL & AOBCS_RW_MASK;
        end else begin
            if (sel_wr) begin
                ctl_q <= i_wdata & AOBCS_RW_MASK;
                // overflow flags: writing one cannot set or keep-clear
                ctl_q[B_OVF]  <= ctl_q[B_OVF] & i_wdata[B_OVF];
                ctl_q[B_FOVF] <= ctl_q[B_FOVF] & i_wdata[B_FOVF];
            end else begin
                ctl_q[B_SW_CLK]  <= 1'b0;
                ctl_q[B_CLR]     <= 1'b0;
                ctl_q[B_SW_TRIG] <= 1'b0;
                if (ld_rdy_q) begin
                    ctl_q[B_LD_REQ] <= 1'b0;
                end
            end
            // set wins over a same-cycle clear
            if (i_host_buf_wr && i_buf_full) begin
                ctl_q[B_OVF] <= 1'b1;
            end
            if (i_host_buf_wr && ctl_q[B_CIRC]) begin
                ctl_q[B_FOVF] <= 1'b1;
            end
        end
    end

    // reload handshake; ready drops with open mode and stays after the request clears
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ld_rdy_q <= 1'b0;
        end else if (!ctl_q[B_CIRC]) begin
            ld_rdy_q <= 1'b0;
        end else if (ctl_q[B_LD_REQ] && i_frame_idx_zero) begin
            ld_rdy_q <= 1'b1;
        end else if (sel_wr && !i_wdata[B_CIRC]) begin
            ld_rdy_q <= 1'b0;
        end
    end

    // initiator pulse: low for the stretch of PULSE_CYC cycles
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pulse_cnt_q <= 3'h0;
        end else if (o_buf_clock && ctl_q[B_CLK_SRC]) begin
            pulse_cnt_q <= 3'(PULSE_CYC);
        end else if (pulse_cnt_q != 3'h0) begin
            pulse_cnt_q <= pulse_cnt_q - 3'h1;
        end
    end
    assign o_oclk_oe  = ctl_q[B_CLK_SRC];
    assign o_oclk_pin = (pulse_cnt_q == 3'h0);

    // datapath holds inactive channel values; mask is all it needs
    assign o_ch_active = ctl_q[B_CH1:B_CH0];
    assign o_buf_clear = ctl_q[B_CLR];
    assign o_circular  = ctl_q[B_CIRC];
    // full or closed buffer refuses host data
    assign o_host_wr_accept = !i_buf_full && !ctl_q[B_CIRC];
    assign o_load_ready = ld_rdy_q;
    assign o_burst_en  = ctl_q[B_BRST_EN];
    assign o_trigger   = ctl_q[B_SW_TRIG] || i_bcr_sw_trig;
    assign o_dma_swap  = ctl_q[B_DMA_SWAP];

    always_comb begin
        o_rdata = ctl_q;
        // no clock is ever refused by this path, so ready stands high
        o_rdata[B_CLK_RDY]  = 1'b1;
        o_rdata[B_LD_RDY]   = ld_rdy_q;
        o_rdata[B_EMPTY]    = i_buf_empty;
        o_rdata[B_THRESH]   = i_buf_thresh;
        o_rdata[B_FULL]     = i_buf_full;
        o_rdata[B_BRST_RDY] = i_burst_ready && ctl_q[B_BRST_EN];
        if (i_addr != ADDR_W'(AOBCS_OFF_CTRL)) begin
            o_rdata = 32'h0000_0000;
        end
    end

    property p_ovf_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_OVF] && !(sel_wr && !i_wdata[B_OVF]) |=> ctl_q[B_OVF];
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky)
        else $error("overflow flag lost");
    property p_ovf_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_host_buf_wr && i_buf_full |=> ctl_q[B_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set)
        else $error("overflow not set");
    property p_fovf_set;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_host_buf_wr && ctl_q[B_CIRC] |=> ctl_q[B_FOVF];
    endproperty
    a_fovf_set: assert property (p_fovf_set)
        else $error("frame overflow not set");
    property p_swclk_once;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_SW_CLK] && !sel_wr |=> !ctl_q[B_SW_CLK];
    endproperty
    a_swclk_once: assert property (p_swclk_once)
        else $error("soft clock did not clear");
    property p_no_clk_disabled;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl_q[B_CLK_EN] && !ctl_q[B_SW_CLK] && !i_bcr_sw_clk
            |-> !o_buf_clock;
    endproperty
    a_no_clk_disabled: assert property (p_no_clk_disabled)
        else $error("clock passed while disabled");
    property p_pulse_len;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_buf_clock && ctl_q[B_CLK_SRC] |=> !o_oclk_pin [*4];
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("initiator pulse too short");
    property p_ldrdy;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_CIRC] && ctl_q[B_LD_REQ] && i_frame_idx_zero |=> ld_rdy_q;
    endproperty
    a_ldrdy: assert property (p_ldrdy)
        else $error("load ready missing");
    property p_reject_full;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_buf_full |-> !o_host_wr_accept;
    endproperty
    a_reject_full: assert property (p_reject_full)
        else $error("full buffer accepted data");
    property p_trig_clear;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_SW_TRIG] && !sel_wr |=> !ctl_q[B_SW_TRIG];
    endproperty
    a_trig_clear: assert property (p_trig_clear)
        else $error("soft trigger did not clear");
    property p_fovf_sticky;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_FOVF] && !(sel_wr && !i_wdata[B_FOVF]) |=> ctl_q[B_FOVF];
    endproperty
    a_fovf_sticky: assert property (p_fovf_sticky)
        else $error("frame overflow flag lost");
    property p_ovf_no_set_by_write;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl_q[B_OVF] && sel_wr && !(i_host_buf_wr && i_buf_full)
            |=> !ctl_q[B_OVF];
    endproperty
    a_ovf_no_set_by_write: assert property (p_ovf_no_set_by_write)
        else $error("overflow flag set by a register write");
    property p_clr_once;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_CLR] && !sel_wr |=> !ctl_q[B_CLR];
    endproperty
    a_clr_once: assert property (p_clr_once)
        else $error("buffer clear did not clear");
    property p_ldreq_drop;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_LD_REQ] && ld_rdy_q && !sel_wr |=> !ctl_q[B_LD_REQ];
    endproperty
    a_ldreq_drop: assert property (p_ldreq_drop)
        else $error("load request stayed after ready");
    property p_swclk_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_SW_CLK] |-> o_buf_clock;
    endproperty
    a_swclk_out: assert property (p_swclk_out)
        else $error("soft clock gave no buffer clock");
    property p_ext_clk;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl_q[B_CLK_SRC] && ctl_q[B_CLK_EN] && ext_fall |-> o_buf_clock;
    endproperty
    a_ext_clk: assert property (p_ext_clk)
        else $error("pin falling edge gave no clock");
    property p_gen_ignored;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl_q[B_CLK_SRC] && i_ratec_tick && !ext_fall && !ctl_q[B_SW_CLK]
            && !i_bcr_sw_clk |-> !o_buf_clock;
    endproperty
    a_gen_ignored: assert property (p_gen_ignored)
        else $error("generator clocked buffer in target mode");
    property p_rsv_zero;
        @(posedge i_clk) disable iff (!i_rst_n)
        o_rdata[31:B_DMA_SWAP+1] == '0 && !o_rdata[B_FULL-1]
            && o_rdata[B_CLK_SRC-1:B_CH1+1] == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved bit read nonzero");
    property p_status_shown;
        @(posedge i_clk) disable iff (!i_rst_n)
        i_addr == ADDR_W'(AOBCS_OFF_CTRL)
            |-> o_rdata[B_EMPTY] == i_buf_empty
            && o_rdata[B_FULL] == i_buf_full
            && o_rdata[B_THRESH] == i_buf_thresh;
    endproperty
    a_status_shown: assert property (p_status_shown)
        else $error("buffer status not shown");
    property p_burst_rdy;
        @(posedge i_clk) disable iff (!i_rst_n)
        !ctl_q[B_BRST_EN] |-> !o_rdata[B_BRST_RDY];
    endproperty
    a_burst_rdy: assert property (p_burst_rdy)
        else $error("burst ready without burst enable");
    property p_trig_out;
        @(posedge i_clk) disable iff (!i_rst_n)
        ctl_q[B_SW_TRIG] |-> o_trigger;
    endproperty
    a_trig_out: assert property (p_trig_out)
        else $error("soft trigger gave no trigger");
    c_ext_clk: cover property (@(posedge i_clk) ext_fall && o_buf_clock);
    c_ovf: cover property (@(posedge i_clk) ctl_q[B_OVF]);
    c_ldrdy: cover property (@(posedge i_clk) $rose(ld_rdy_q));
    c_fovf: cover property (@(posedge i_clk) ctl_q[B_FOVF]);
    c_int_pulse: cover property (@(posedge i_clk)
        o_buf_clock && ctl_q[B_CLK_SRC]);
endmodule

// [design/aobcs_pkg.sv]
// package: register map, fields and timing for the output buffer control reg
package aobcs_pkg;
    localparam logic [7:0]  AOBCS_OFF_CTRL  = 8'h3c;
    localparam logic [31:0] AOBCS_RST_VAL   = 32'h0000_1043;
    localparam int B_CH0      = 0;
    localparam int B_CH1      = 1;
    localparam int B_CLK_SRC  = 4;
    localparam int B_CLK_EN   = 5;
    localparam int B_CLK_RDY  = 6;
    localparam int B_SW_CLK   = 7;
    localparam int B_CIRC     = 8;
    localparam int B_LD_REQ   = 9;
    localparam int B_LD_RDY   = 10;
    localparam int B_CLR      = 11;
    localparam int B_EMPTY    = 12;
    localparam int B_THRESH   = 13;
    localparam int B_FULL     = 15;
    localparam int B_OVF      = 16;
    localparam int B_FOVF     = 17;
    localparam int B_BRST_RDY = 18;
    localparam int B_BRST_EN  = 19;
    localparam int B_SW_TRIG  = 20;
    localparam int B_DMA_SWAP = 21;
    localparam logic [31:0] AOBCS_RW_MASK = 32'h003b_0bb3;
    localparam int CLK_NS        = 25;
    localparam int PULSE_NS      = 100;
    localparam int PULSE_CYC     = (PULSE_NS + CLK_NS - 1) / CLK_NS;
endpackage

// [test/aobcs_ctrl_bench.sv]
// self-checking bench for the output buffer control/status register
`timescale 1ns/1ps
module aobcs_ctrl_bench
    import aobcs_pkg::*;
;
    logic        i_clk, i_rst_n, i_wr, i_buf_empty, i_buf_full;
    logic        i_buf_thresh, i_burst_ready, i_oclk_pin;
    logic [4:0]  pl;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic [1:0]  o_ch_active;
    logic        o_buf_clock, o_buf_clear, o_host_wr_accept, o_circular;
    logic        o_load_ready, o_burst_en, o_trigger, o_dma_swap;
    logic        o_oclk_pin, o_oclk_oe;
    int          miscompares, comparisons, cyc, nclk, nlow, nclr, ntrig;

    aobcs_ctrl dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata),
        .i_buf_empty(i_buf_empty), .i_buf_full(i_buf_full),
        .i_buf_thresh(i_buf_thresh), .i_frame_idx_zero(pl[0]),
        .i_host_buf_wr(pl[1]), .i_burst_ready(i_burst_ready),
        .i_ratec_tick(pl[2]), .i_bcr_sw_clk(pl[3]), .i_bcr_sw_trig(pl[4]),
        .o_ch_active(o_ch_active), .o_buf_clock(o_buf_clock),
        .o_buf_clear(o_buf_clear), .o_host_wr_accept(o_host_wr_accept),
        .o_circular(o_circular), .o_load_ready(o_load_ready),
        .o_burst_en(o_burst_en), .o_trigger(o_trigger),
        .o_dma_swap(o_dma_swap), .i_oclk_pin(i_oclk_pin),
        .o_oclk_pin(o_oclk_pin), .o_oclk_oe(o_oclk_oe));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    // event counters; a pulse seen twice would show as a count of two
    always @(posedge i_clk) begin
        nclk  += o_buf_clock;
        nlow  += !o_oclk_pin;
        nclr  += o_buf_clear;
        ntrig += o_trigger;
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            summarize();
        end
    end

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr(logic [31:0] d);
        @(posedge i_clk);
        i_wr    <= 1'b1;
        i_addr  <= AOBCS_OFF_CTRL;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr    <= 1'b0;
        repeat (3) @(posedge i_clk);
    endtask

    // masked read: bits outside m are not judged
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        @(posedge i_clk);
        i_addr <= a;
        #1 chk("rdata", o_rdata & m, e);
    endtask

    task automatic pulse(int k);
        @(posedge i_clk);
        pl[k] <= 1'b1;
        @(posedge i_clk);
        pl[k] <= 1'b0;
        repeat (6) @(posedge i_clk);
    endtask

    task automatic fall();
        @(posedge i_clk);
        i_oclk_pin <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_oclk_pin <= 1'b1;
        repeat (3) @(posedge i_clk);
    endtask

    task automatic zc();
        @(negedge i_clk);
        nclk = 0;
        nlow = 0;
        nclr = 0;
        ntrig = 0;
    endtask

    task automatic summarize();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_wr = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_buf_empty = 1'b1;
        i_buf_full = 1'b0;
        i_buf_thresh = 1'b0;
        i_burst_ready = 1'b1;
        i_oclk_pin = 1'b1;
        pl = 5'h00;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(AOBCS_OFF_CTRL, AOBCS_RST_VAL, 32'hffff_ffff);
        rd(8'h40, 32'h0, 32'hffff_ffff);
        chk("oe", o_oclk_oe, 32'h0);
        zc();
        // all ones: self-clearing bits fire once, overflow flags stay clear
        wr(32'hffff_ffff);
        rd(AOBCS_OFF_CTRL, 32'h002c_1373, 32'hffff_ffff);
        chk("ctl", {o_ch_active, o_circular, o_burst_en, o_dma_swap,
            o_oclk_oe}, 32'h3f);
        chk("swclk", nclk, 32'h1);
        // the low pulse is still running when the read returns
        repeat (2) @(posedge i_clk);
        chk("low", nlow, PULSE_CYC);
        chk("clr", nclr, 32'h1);
        chk("trig", ntrig, 32'h1);
        pulse(0);
        rd(AOBCS_OFF_CTRL, 32'h002c_1573, 32'hffff_ffff);
        chk("ldrdy", o_load_ready, 32'h1);
        pulse(1);
        rd(AOBCS_OFF_CTRL, 32'h002e_1573, 32'hffff_ffff);
        wr(32'h0002_0033);
        rd(AOBCS_OFF_CTRL, 32'h0002_1073, 32'hffff_fbff);
        @(posedge i_clk);
        i_buf_full <= 1'b1;
        i_buf_empty <= 1'b0;
        i_buf_thresh <= 1'b1;
        pulse(1);
        rd(AOBCS_OFF_CTRL, 32'h0003_a073, 32'hffff_fbff);
        chk("accept", o_host_wr_accept, 32'h0);
        wr(32'h0000_0033);
        rd(AOBCS_OFF_CTRL, 32'h0000_a073, 32'hffff_fbff);
        @(posedge i_clk);
        i_buf_full <= 1'b0;
        wr(32'h0000_0020);
        chk("mask", o_ch_active, 32'h0);
        chk("accept1", o_host_wr_accept, 32'h1);
        zc();
        fall();
        pulse(2);
        chk("tgt", nclk, 32'h1);
        wr(32'h0000_0000);
        fall();
        chk("dis", nclk, 32'h1);
        wr(32'h0000_0030);
        zc();
        pulse(2);
        chk("int", {nclk[15:0], nlow[15:0]}, {16'h1, 16'(PULSE_CYC)});
        wr(32'h0000_0010);
        pulse(2);
        chk("intdis", nclk, 32'h1);
        pulse(3);
        chk("mirclk", nclk, 32'h2);
        pulse(4);
        chk("mirtrg", ntrig, 32'h1);
        summarize();
    end
endmodule
